// [verilog/rtc_device.sv]
// Purpose: seconds-counter clock device reached as a two-wire bus slave
// Assumes: scl, sda, osc32k and vccAboveVpf are asynchronous to clk
// Notes: reset pin, oscillator gating and charger decode are outputs
// Notes on behaviour
// RQ1: no register access during supply failure
// RQ2: backup power keeps oscillator and counter running; both stop on backup while control bit 7 is high
// RQ3: control bit 7 low runs oscillator
// RQ4: main power: oscillator on, counter needs bit low
// RQ5: supply failure asserts reset, blocks bus access
// RQ6: reset held for release delay after return
// RQ7: oscillator off adds startup time to hold
// RQ8: charger enabled only by pattern 1010
// RQ9: trickle register resets to zero
// RQ10: diode field 01 none, 10 one, else off
// RQ11: resistor field 01/10/11 sizes, 00 off
// RQ12: host avoids smallest resistor above 3.63V
// RQ13: device is slave; master makes clock, conditions
// RQ14: works at 100kHz and 400kHz clock
// RQ15: sda fall with scl high START, rise STOP
// RQ16: data changes only while scl low
// RQ17: master starts only on an idle bus
// RQ18: bytes with ninth-clock acknowledge, any count
// RQ19: answers only to address 1101000 plus direction
// RQ20: counter 00h-03h lsb first, control, trickle
// RQ21: pointer advances per byte, wraps 05h to 00h
// RQ22: read starts at current pointer
// RQ23: divide 32768 Hz to one-second counter tick
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_device #(
  parameter int RELEASE_CYCLES = `RST_RELEASE_US * (`CLK_HZ / 1000000),
  parameter int OSC_START_CYCLES = `OSC_START_US * (`CLK_HZ / 1000000),
  parameter int OSC_DIV = `OSC_HZ
) (
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.device link,
  input wire logic osc32k,
  input wire logic vccAboveVpf,
  output logic rstOe,
  output logic oscRunning,
  output logic [31:0] counterValue,
  output logic chargerOn,
  output logic diodeOn,
  output logic [1:0] resistorSel
);
  // refuse counts that the hold counter or the 16-bit divider cannot serve
  generate
    if (RELEASE_CYCLES < 1 || OSC_START_CYCLES < 0 || OSC_DIV < 2 || OSC_DIV > 65536) begin : g_chk
      $error("rtc_device: bad timing parameter");
    end
  endgenerate

  // ==========================================================
  // input synchronisers
  logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3;
  logic oscS1, oscS2, oscS3, vccS1, vccS2;
  // two flops before use; the third only holds history for edges
  always_ff @(posedge clk) begin
    sclS1 <= link.scl;
    sclS2 <= sclS1;
    sclS3 <= sclS2;
    sdaS1 <= link.sda;
    sdaS2 <= sdaS1;
    sdaS3 <= sdaS2;
    oscS1 <= osc32k;
    oscS2 <= oscS1;
    oscS3 <= oscS2;
    vccS1 <= vccAboveVpf;
    vccS2 <= vccS1;
  end

  logic powerFail, sclRise, sclFall, startCond, stopCond;
  assign powerFail = ~vccS2;
  // sampling at 200 MHz leaves wide margin at 400 kHz
  // RQ14 sampled edges
  assign sclRise = sclS2 & ~sclS3;
  assign sclFall = ~sclS2 & sclS3;
  // RQ15 start and stop
  assign startCond = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopCond = sclS2 & sclS3 & ~sdaS3 & sdaS2;

  // ==========================================================
  // registers
  logic [7:0] ctrl_q, trickle_q;
  logic [31:0] count_q;
  logic [2:0] ptr_q;
  logic oscOff;
  assign oscOff = ctrl_q[`OSC_OFF_BIT];

  // register byte at a pointer location
  function automatic logic [7:0] regRead(input logic [2:0] p, input logic [31:0] c,
                                         input logic [7:0] k, input logic [7:0] t);
    case (p)
      3'h0: regRead = c[7:0];
      3'h1: regRead = c[15:8];
      3'h2: regRead = c[23:16];
      3'h3: regRead = c[31:24];
      `REG_CTRL: regRead = k;
      `REG_TRICKLE: regRead = t;
      default: regRead = 8'h00;
    endcase
  endfunction : regRead

  // pointer step with wrap past the last register
  function automatic logic [2:0] ptrNext(input logic [2:0] p);
    ptrNext = (p >= `REG_LAST) ? 3'h0 : p + 3'h1;
  endfunction : ptrNext

  // ==========================================================
  // oscillator and seconds divider
  logic [15:0] div_q;
  logic secTick;
  // RQ2 RQ3 oscillator runs on main power or with bit low
  assign oscRunning = vccS2 | ~oscOff;
  // RQ23 one tick per 32768 edges
  assign secTick = oscRunning & oscS2 & ~oscS3 && (div_q == 16'(OSC_DIV - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 16'h0000;
    end else if (oscRunning & oscS2 & ~oscS3) begin
      div_q <= secTick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // ==========================================================
  // slave state machine
  rtc_pkg::slave_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q, tx_q;
  logic ack_q, sdaOe_q, wrEn;
  logic [7:0] rxByte;
  assign rxByte = shift_q;
  // RQ1 writes land only with the supply good
  assign wrEn = sclFall && bitCnt_q == 4'h7 && state_q == rtc_pkg::S_WRITE && !powerFail;

  // RQ13 the slave only follows master edges
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rtc_pkg::S_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      ptr_q <= 3'h0;
    // RQ5 supply failure drops the link
    end else if (powerFail || stopCond) begin
      state_q <= rtc_pkg::S_IDLE;
      ack_q <= 1'b0;
    end else if (startCond) begin
      state_q <= rtc_pkg::S_ADDR;
      // parked at 8 so the scl fall that closes the start wraps it to bit 0
      bitCnt_q <= 4'h8;
      ack_q <= 1'b0;
    end else if (sclRise) begin
      // RQ16 data taken while scl high
      if (bitCnt_q < 4'h8) begin
        shift_q <= {shift_q[6:0], sdaS2};
      // RQ18 master nack ends a read
      end else if (state_q == rtc_pkg::S_READ && sdaS2) begin
        state_q <= rtc_pkg::S_IGNORE;
      end
    end else if (sclFall) begin
      bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
      ack_q <= 1'b0;
      if (bitCnt_q == 4'h7) begin
        case (state_q)
          // RQ19 address match
          rtc_pkg::S_ADDR: begin
            if (rxByte[7:1] == `RTC_SLAVE_ADDR) begin
              ack_q <= 1'b1;
              // RQ22 first read byte fetched after the ack bit, from ptr_q as it stands
              state_q <= rxByte[0] ? rtc_pkg::S_READ : rtc_pkg::S_PTR;
            end else begin
              state_q <= rtc_pkg::S_IGNORE;
            end
          end
          rtc_pkg::S_PTR: begin
            ack_q <= 1'b1;
            ptr_q <= (rxByte > 8'(`REG_LAST)) ? 3'h0 : rxByte[2:0];
            state_q <= rtc_pkg::S_WRITE;
          end
          // RQ21 advance after each written byte
          rtc_pkg::S_WRITE: begin
            ack_q <= 1'b1;
            ptr_q <= ptrNext(ptr_q);
          end
          default: begin
            ack_q <= 1'b0;
          end
        endcase
      end else if (bitCnt_q == 4'h8 && state_q == rtc_pkg::S_READ) begin
        // RQ21 RQ22 next read byte from the pointer, which wraps
        tx_q <= regRead(ptr_q, count_q, ctrl_q, trickle_q);
        ptr_q <= ptrNext(ptr_q);
      end
    end
  end

  // sda driven low for ack or a zero data bit, changed after scl fall
  // RQ16 drive changes follow scl fall
  always_ff @(posedge clk) begin
    if (rst) begin
      sdaOe_q <= 1'b0;
    end else begin
      sdaOe_q <= ack_q | (state_q == rtc_pkg::S_READ && bitCnt_q < 4'h8
                 && !tx_q[3'(4'h7 - bitCnt_q)]);
    end
  end
  assign link.slaveSdaOe = sdaOe_q;

  // ==========================================================
  // counter, control and trickle registers
  // a bus write wins over the tick in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 32'h0000_0000;
    end else if (wrEn && ptr_q <= `REG_CNT3) begin
      // RQ20 counter bytes lsb first
      count_q[8*ptr_q[1:0] +: 8] <= rxByte;
    // RQ4 counter advances only with bit low
    end else if (secTick && !oscOff) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end
  assign counterValue = count_q;

  // RQ9 trickle register clears at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
      trickle_q <= `TRICKLE_RESET;
    end else if (wrEn && ptr_q == `REG_CTRL) begin
      ctrl_q <= {rxByte[`OSC_OFF_BIT], 7'h00};
    end else if (wrEn && ptr_q == `REG_TRICKLE) begin
      trickle_q <= rxByte;
    end
  end

  // RQ8 RQ10 RQ11 charger decode
  always_ff @(posedge clk) begin
    if (rst) begin
      chargerOn <= 1'b0;
      diodeOn <= 1'b0;
      resistorSel <= 2'h0;
    end else begin
      chargerOn <= trickle_q[7:4] == `CHG_PATTERN && ^trickle_q[3:2] && |trickle_q[1:0];
      diodeOn <= trickle_q[3:2] == 2'h2;
      resistorSel <= trickle_q[1:0];
    end
  end

  // ==========================================================
  // reset output hold
  logic [31:0] hold_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 32'(RELEASE_CYCLES);
      rstOe <= 1'b1;
    end else begin
      // RQ5 assert on failure; RQ6 RQ7 hold after return
      if (powerFail) begin
        hold_q <= 32'(RELEASE_CYCLES) + (oscOff ? 32'(OSC_START_CYCLES) : 32'h0);
      end else if (hold_q != 32'h0) begin
        hold_q <= hold_q - 32'h1;
      end
      rstOe <= powerFail || hold_q > 32'h1;
    end
  end
endmodule : rtc_device
`default_nettype wire

// [verilog/rtc_defs.svh]
// Purpose: shared constants of the seconds-counter clock and its bus master
// Assumes: 200 MHz system clock
// Notes: offsets, fields, resets and timing counts
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define CLK_HZ 200000000
`define OSC_HZ 32768
`define SCL_HZ 400000
`define RTC_SLAVE_ADDR 7'h68
`define REG_CNT0 3'h0
`define REG_CNT3 3'h3
`define REG_CTRL 3'h4
`define REG_TRICKLE 3'h5
`define REG_LAST 3'h5
`define CTRL_RESET 8'h00
`define TRICKLE_RESET 8'h00
`define OSC_OFF_BIT 7
`define CHG_PATTERN 4'hA
`define RST_RELEASE_US 1000
`define OSC_START_US 1000
`define HOST_CMD 4'h0
`define HOST_TX 4'h4
`define HOST_RX 4'h8
`define HOST_STATUS 4'hC
`define CMD_START 0
`define CMD_STOP 1
`define CMD_READ 2
`define CMD_NACK 3
`endif

// [verilog/rtc_pkg.sv]
// Purpose: types of the seconds-counter clock and its bus master
// Assumes: constants come from rtc_defs.svh
// Notes: one-hot state codes
`default_nettype none
package rtc_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_ADDR = 6'h02, S_PTR = 6'h04,
    S_WRITE = 6'h08, S_READ = 6'h10, S_IGNORE = 6'h20
  } slave_state_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_START = 4'h2, H_BITS = 4'h4, H_STOP = 4'h8
  } host_state_t;
endpackage : rtc_pkg
`default_nettype wire

// [verilog/i2c_link_if.sv]
// Purpose: open-drain two-wire link between bus master and clock device
// Assumes: pull-ups on both lines
// Notes: a line is low while any enable is high
`timescale 1ns/100ps
`default_nettype none
interface i2c_link_if;
  logic masterSclOe;
  logic masterSdaOe;
  logic slaveSdaOe;
  wire logic scl;
  wire logic sda;
  // wired-and of the open-drain drivers
  assign scl = ~masterSclOe;
  assign sda = ~(masterSdaOe | slaveSdaOe);
  modport device (input scl, input sda, output slaveSdaOe);
  modport host (input scl, input sda, output masterSclOe, output masterSdaOe);
endinterface : i2c_link_if
`default_nettype wire

// [verilog/rtc_host.sv]
// Purpose: two-wire bus master driven by software over Avalon-MM
// Assumes: single master on the link
// Notes: one byte per command, optional start before and stop after
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_host #(
  parameter int QUARTER = `CLK_HZ / (4 * `SCL_HZ)
) (
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.host link,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  generate
    if (QUARTER < 4 || QUARTER > 65535) begin : g_chk
      $error("rtc_host: bad QUARTER");
    end
  endgenerate

  // ==========================================================
  // line synchronisers
  logic sclS1, sclS2, sdaS1, sdaS2;
  always_ff @(posedge clk) begin
    sclS1 <= link.scl;
    sclS2 <= sclS1;
    sdaS1 <= link.sda;
    sdaS2 <= sdaS1;
  end

  // ==========================================================
  // bus engine
  rtc_pkg::host_state_t state_q;
  logic [15:0] q_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [3:0] cmd_q;
  logic [7:0] tx_q, rx_q;
  logic nack_q, own_q, sclOe_q, sdaOe_q, busy, phEnd, cmdWr;
  assign busy = state_q != rtc_pkg::H_IDLE;
  assign phEnd = q_q == 16'(QUARTER - 1);
  assign cmdWr = write && address == `HOST_CMD;

  // RQ13 master owns clock and conditions
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rtc_pkg::H_IDLE;
      q_q <= 16'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      cmd_q <= 4'h0;
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      own_q <= 1'b0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end else begin
      q_q <= (phEnd || !busy) ? 16'h0 : q_q + 16'h1;
      case (state_q)
        rtc_pkg::H_IDLE: begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          if (cmdWr) begin
            cmd_q <= writedata[3:0];
            state_q <= writedata[`CMD_START] ? rtc_pkg::H_START : rtc_pkg::H_BITS;
          end
        end
        // RQ15 RQ17 start only from an idle or owned bus
        rtc_pkg::H_START: if (phEnd && (own_q || ph_q != 2'h0 || (sclS2 && sdaS2))) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sdaOe_q <= 1'b0;
            2'h1: sclOe_q <= 1'b0;
            2'h2: sdaOe_q <= 1'b1;
            default: begin
              sclOe_q <= 1'b1;
              own_q <= 1'b1;
              state_q <= rtc_pkg::H_BITS;
            end
          endcase
        end
        // RQ16 RQ18 eight bits plus ack, sda set while scl low
        rtc_pkg::H_BITS: if (phEnd) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              if (bit_q < 4'h8) begin
                sdaOe_q <= !cmd_q[`CMD_READ] && !tx_q[3'(4'h7 - bit_q)];
              end else begin
                sdaOe_q <= cmd_q[`CMD_READ] && !cmd_q[`CMD_NACK];
              end
            end
            2'h1: sclOe_q <= 1'b0;
            2'h2: begin
              if (bit_q < 4'h8) begin
                rx_q <= {rx_q[6:0], sdaS2};
              end else begin
                nack_q <= sdaS2;
              end
            end
            default: begin
              sclOe_q <= 1'b1;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                sdaOe_q <= 1'b0;
                state_q <= cmd_q[`CMD_STOP] ? rtc_pkg::H_STOP : rtc_pkg::H_IDLE;
              end
            end
          endcase
        end
        rtc_pkg::H_STOP: if (phEnd) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sdaOe_q <= 1'b1;
            2'h1: sclOe_q <= 1'b0;
            2'h2: sdaOe_q <= 1'b0;
            default: begin
              own_q <= 1'b0;
              state_q <= rtc_pkg::H_IDLE;
            end
          endcase
        end
        default: state_q <= rtc_pkg::H_IDLE;
      endcase
    end
  end
  assign link.masterSclOe = sclOe_q;
  assign link.masterSdaOe = sdaOe_q;

  // ==========================================================
  // software registers; command writes stall while busy
  logic rdDone_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (write && address == `HOST_TX && !busy) begin
      tx_q <= writedata[7:0];
    end
  end

  // read data registered, so reads answer one cycle late
  always_ff @(posedge clk) begin
    if (rst) begin
      rdDone_q <= 1'b0;
      readdata <= 32'h0;
    end else begin
      rdDone_q <= read && !rdDone_q;
      case (address)
        `HOST_TX: readdata <= {24'h0, tx_q};
        `HOST_RX: readdata <= {24'h0, rx_q};
        `HOST_STATUS: readdata <= {29'h0, own_q, nack_q, busy};
        default: readdata <= 32'h0;
      endcase
    end
  end
  assign waitrequest = (read && !rdDone_q) || (write && busy);
endmodule : rtc_host
`default_nettype wire

// [tb/rtc_link_props.sv]
// Purpose: wire-level checks on the two-wire link between bus master and clock device
// Assumes: master quarter period of at least 4 clocks
// Notes: sees only the link signals, the clock and the reset
`timescale 1ns/100ps
`default_nettype none
module rtc_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterSclOe,
  input wire logic masterSdaOe,
  input wire logic slaveSdaOe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // reset and drive ownership
  // lines released in reset
  AST_RESET_QUIET: assert property (disable iff (1'h0)
    rst |=> !masterSclOe && !masterSdaOe && !slaveSdaOe)
    else $error("link driven during reset");
  AST_SLAVE_CHANGE_LOW: assert property ($changed(slaveSdaOe) |-> !scl)
    else $error("slave changed sda while scl high");
  AST_SLAVE_HOLD_HIGH: assert property ($rose(scl) |=> $stable(slaveSdaOe)[*3])
    else $error("slave bit not held through scl high");
  AST_NO_FIGHT: assert property (slaveSdaOe && scl |-> !masterSdaOe)
    else $error("master drives sda during slave bit");
  // ==========================================================
  // bus conditions and clock shape
  // sda changes only as conditions
  AST_SDA_STABLE_HIGH: assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(masterSdaOe))
    else $error("sda changed with scl high outside start or stop");
  AST_START_HOLD: assert property (scl && $fell(sda) |-> scl[*3] ##[1:40] !scl)
    else $error("start condition not followed by clock low in time");
  AST_STOP_IDLE: assert property (scl && $rose(sda) |-> !masterSclOe[*4])
    else $error("clock pulled too soon after stop");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*3])
    else $error("clock high phase too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl[*3])
    else $error("clock low phase too short");
  // main scenarios seen on the wire
  COV_START: cover property (scl && $fell(sda));
  COV_STOP: cover property (scl && $rose(sda));
  COV_ACK: cover property ($rose(scl) && slaveSdaOe);
endmodule : rtc_link_props
`default_nettype wire

// [tb/seconds_counter_rtc_power_charger_tb_top.sv]
// Purpose: self-checking bench for the clock device and its bus master
// Assumes: shortened hold, divider and quarter counts
// Notes: bench drives the master's Avalon side; both ends share one link
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"
module seconds_counter_rtc_power_charger_tb_top;
  localparam int REL = 50;
  localparam int OSCST = 50;
  localparam logic [55:0] READ_IMG = 56'h78008012345678;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic osc32k = 1'h0;
  logic vccAboveVpf = 1'h1;
  logic [3:0] address = 4'h0;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic rstOe;
  logic oscRunning;
  logic chargerOn;
  logic diodeOn;
  logic [1:0] resistorSel;
  logic [31:0] counterValue;
  logic [7:0] rbuf [8];
  logic [7:0] tv [9] = '{8'hA3, 8'hAE, 8'hA8, 8'h5A, 8'h2A, 8'hA5, 8'hAA, 8'hAB, 8'hA7};
  logic [7:0] rx;
  logic nack;
  logic on;
  logic [31:0] c0;
  logic [31:0] q;
  int nFail = 0;
  int samplesChecked = 0;
  // ==========================================================
  // clocks: crystal stand-in is unrelated in phase to clk
  always #2.5 clk = ~clk;
  always #32 osc32k = ~osc32k;
  // ==========================================================
  // both ends joined by the link, checker beside it
  i2c_link_if i2c_link_if_inst ();
  rtc_device #(.RELEASE_CYCLES(REL), .OSC_START_CYCLES(OSCST), .OSC_DIV(4)) rtc_device_inst (
    .clk(clk), .rst(rst), .link(i2c_link_if_inst.device), .osc32k(osc32k),
    .vccAboveVpf(vccAboveVpf), .rstOe(rstOe), .oscRunning(oscRunning),
    .counterValue(counterValue), .chargerOn(chargerOn), .diodeOn(diodeOn),
    .resistorSel(resistorSel));
  rtc_host #(.QUARTER(4)) rtc_host_inst (
    .clk(clk), .rst(rst), .link(i2c_link_if_inst.host), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  rtc_link_props rtc_link_props_inst (
    .clk(clk), .rst(rst), .masterSclOe(i2c_link_if_inst.masterSclOe),
    .masterSdaOe(i2c_link_if_inst.masterSdaOe), .slaveSdaOe(i2c_link_if_inst.slaveSdaOe),
    .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda));
  // ==========================================================
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one Avalon cycle; request held until waitrequest is seen low
  task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= ~rd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 5000);
    r = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (n >= 5000) chk("avalon wait", 32'h0, 32'h1);
  endtask : av
  // one byte on the link; waits on the busy flag, then fetches status and received byte
  task automatic xfer(input logic [3:0] cmd, input logic [7:0] tx);
    logic [31:0] s;
    int n;
    n = 0;
    if (!cmd[2]) av(1'h0, `HOST_TX, {24'h0, tx}, s);
    av(1'h0, `HOST_CMD, {28'h0, cmd}, s);
    do begin
      av(1'h1, `HOST_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'h0 && n < 500);
    if (n >= 500) chk("busy wait", 32'h0, 32'h1);
    nack = s[1];
    av(1'h1, `HOST_RX, 32'h0, s);
    rx = s[7:0];
  endtask : xfer
  // write transaction: address byte, pointer, cnt bytes lsb first, stop
  task automatic dev_wr(input logic [7:0] ptr, input logic [31:0] d, input int cnt);
    xfer(4'h1, 8'hD0);
    chk("address ack", 32'h0, {31'h0, nack});
    xfer(4'h0, ptr);
    for (int i = 0; i < cnt; i++) begin
      xfer((i == cnt - 1) ? 4'h2 : 4'h0, d[8 * i +: 8]);
      chk("data ack", 32'h0, {31'h0, nack});
    end
  endtask : dev_wr
  // read transaction, optionally after a pointer write; last byte refused, then stop
  task automatic dev_rd(input logic setPtr, input logic [7:0] ptr, input int cnt);
    if (setPtr) begin
      xfer(4'h1, 8'hD0);
      xfer(4'h0, ptr);
    end
    xfer(4'h1, 8'hD1);
    for (int i = 0; i < cnt; i++) begin
      xfer((i == cnt - 1) ? 4'hE : 4'h4, 8'h00);
      rbuf[i] = rx;
    end
  endtask : dev_rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // watchdog: the sequence needs roughly 11000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (40) @(posedge clk);
    chk("reset hold", 32'h1, {31'h0, rstOe});
    repeat (30) @(posedge clk);
    chk("reset released", 32'h0, {31'h0, rstOe});
    chk("charger after reset", 32'h0, {29'h0, chargerOn, resistorSel});
    c0 = counterValue;
    repeat (512) @(posedge clk);
    chk("ticks in 512 cycles", 32'h1, {31'h0, (counterValue - c0) inside {[9:11]}});
    av(1'h1, 4'h2, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    xfer(4'h3, 8'hD2);
    chk("foreign address", 32'h1, {31'h0, nack});
    // stopped counter keeps the written image steady
    dev_wr(8'h04, 32'h80, 1);
    dev_wr(8'h00, 32'h12345678, 4);
    chk("counter image", 32'h12345678, counterValue);
    chk("oscillator on main", 32'h1, {31'h0, oscRunning});
    repeat (300) @(posedge clk);
    chk("counter held", 32'h12345678, counterValue);
    dev_rd(1'h1, 8'h00, 7);
    for (int i = 0; i < 7; i++) begin
      chk("read back", {24'h0, READ_IMG[8 * i +: 8]}, {24'h0, rbuf[i]});
    end
    // smallest resistor only because the bench supply stays low
    foreach (tv[i]) begin
      dev_wr(8'h05, {24'h0, tv[i]}, 1);
      on = tv[i][7:4] == 4'hA && (tv[i][3:2] == 2'h1 || tv[i][3:2] == 2'h2) && tv[i][1:0] != 2'h0;
      chk("charger enable", {31'h0, on}, {31'h0, chargerOn});
      chk("resistor field", {30'h0, tv[i][1:0]}, {30'h0, resistorSel});
      if (on) chk("diode field", {31'h0, tv[i][3:2] == 2'h2}, {31'h0, diodeOn});
    end
    dev_rd(1'h0, 8'h00, 1);
    chk("read at wrapped pointer", 32'h78, {24'h0, rbuf[0]});
    // supply failure with the oscillator enabled
    dev_wr(8'h04, 32'h00, 1);
    @(posedge clk);
    vccAboveVpf <= 1'h0;
    repeat (6) @(posedge clk);
    chk("reset on failure", 32'h1, {31'h0, rstOe});
    xfer(4'h3, 8'hD0);
    chk("access refused", 32'h1, {31'h0, nack});
    c0 = counterValue;
    repeat (300) @(posedge clk);
    chk("backup counting", 32'h1, {31'h0, (counterValue - c0) inside {[5:6]}});
    @(posedge clk);
    vccAboveVpf <= 1'h1;
    repeat (40) @(posedge clk);
    chk("hold after return", 32'h1, {31'h0, rstOe});
    repeat (40) @(posedge clk);
    chk("release after return", 32'h0, {31'h0, rstOe});
    chk("charger kept", 32'h1, {31'h0, chargerOn});
    // supply failure with the oscillator disabled
    dev_wr(8'h04, 32'h80, 1);
    @(posedge clk);
    vccAboveVpf <= 1'h0;
    repeat (6) @(posedge clk);
    chk("standby oscillator", 32'h0, {31'h0, oscRunning});
    c0 = counterValue;
    repeat (300) @(posedge clk);
    chk("standby counter", c0, counterValue);
    @(posedge clk);
    vccAboveVpf <= 1'h1;
    repeat (75) @(posedge clk);
    chk("long hold", 32'h1, {31'h0, rstOe});
    repeat (60) @(posedge clk);
    chk("long hold released", 32'h0, {31'h0, rstOe});
    conclude();
  end
endmodule : seconds_counter_rtc_power_charger_tb_top
`default_nettype wire
